// ===== design/srl_latch.sv
// set/reset latch with selectable sources and apb registers
`timescale 1ns/10ps
module srl_latch
   import srl_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // latch sources
   input  wire logic        cmp_a_out,
   input  wire logic        cmp_b_out,
   input  wire logic        t1_clk_en,
   input  wire logic        ext_latch_input,
   // pins
   output logic             q_pin_out,
   output logic             q_pin_oe_n,
   output logic             nq_pin_out,
   output logic             nq_pin_oe_n,
   // state
   output logic             latch_state
);

   srl_state_s st_q;
   srl_state_s st_d;
   logic       latch_q;
   logic       cmp_a_out_synced;
   logic       cmp_b_out_synced;
   logic       set_eff;
   logic       rst_eff;
   logic       setup;
   logic       access;
   logic       wr_ok;

   localparam srl_state_s ST_RST = '{
      ctrl0:           srl_ctrl0_s'(SRL_CTRL0_RST),
      set_en:          srl_src_s'(SRL_CTRL1_RST[SRL_SET_EN_LSB +: 4]),
      rst_en:          srl_src_s'(SRL_CTRL1_RST[SRL_RST_EN_LSB +: 4]),
      ctrl2:           srl_ctrl2_s'(SRL_CTRL2_RST),
      sw_set_strobe:   1'b0,
      sw_reset_strobe: 1'b0,
      per_cnt:         '0,
      per_pulse:       1'b0,
      pready:          1'b0,
      pslverr:         1'b0,
      prdata:          32'h0000_0000,
      q_pin:           1'b0,
      q_oe_n:          1'b1,
      nq_pin:          1'b0,
      nq_oe_n:         1'b1
   };

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == SRL_CTRL0_OFS) || (a == SRL_CTRL1_OFS) ||
                (a == SRL_CTRL2_OFS) || (a == SRL_STAT_OFS);
   endfunction

   // true once the counter reaches the end of the selected period
   function automatic logic period_hit(input logic [SRL_PER_CNT_W-1:0] cnt,
                                       input logic [2:0]               sel);
      logic [SRL_PER_CNT_W-1:0] mask;
      mask = SRL_PER_CNT_W'((1 << (int'(sel) + SRL_PER_BASE)) - 1);
      period_hit = ((cnt & mask) == mask);
   endfunction

   // comparator synchronisers
   srl_cmp_sync u_sync_a (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (t1_clk_en),
      .sync_en (st_q.ctrl2.sync_a),
      .raw     (cmp_a_out),
      .out     (cmp_a_out_synced)
   ); // R7

   srl_cmp_sync u_sync_b (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (t1_clk_en),
      .sync_en (st_q.ctrl2.sync_b),
      .raw     (cmp_b_out),
      .out     (cmp_b_out_synced)
   ); // R7

   // source selection, all active high
   always_comb begin
      set_eff = (st_q.set_en.cmp_a & cmp_a_out_synced)  // R6 R2
              | (st_q.set_en.cmp_b & cmp_b_out_synced)  // R6
              | (st_q.set_en.ext   & ext_latch_input)   // R8
              | (st_q.set_en.per   & st_q.per_pulse)    // R10
              | st_q.sw_set_strobe;                     // R15 R4
      rst_eff = (st_q.rst_en.cmp_a & cmp_a_out_synced)  // R6 R2
              | (st_q.rst_en.cmp_b & cmp_b_out_synced)  // R6
              | (st_q.rst_en.ext   & ext_latch_input)   // R8
              | (st_q.rst_en.per   & st_q.per_pulse)    // R10
              | st_q.sw_reset_strobe;                   // R15 R4
   end

   // latch core: no reset, so state is undefined until software acts;
   // sampling on ref_clk bounds the response to one cycle, no edge wait
   always_ff @(posedge ref_clk) begin
      if (rst_eff) begin
         latch_q <= 1'b0; // R3 R1 R14
      end else if (set_eff) begin
         latch_q <= 1'b1; // R1
      end
   end

   assign setup  = psel & ~penable;
   assign access = psel & penable & st_q.pready;
   assign wr_ok  = access & pwrite & ~st_q.pslverr;

   always_comb begin
      st_d = st_q;

      // apb: zero wait, answer in the first access cycle
      st_d.pready  = setup;
      st_d.pslverr = setup & ~addr_ok(paddr);
      if (setup && !pwrite) begin
         unique case (paddr)
            SRL_CTRL0_OFS: st_d.prdata = {25'h0000000,
                                          st_q.ctrl0.periodic_clk_period_sel,
                                          st_q.ctrl0.true_out_en,
                                          st_q.ctrl0.compl_out_en,
                                          2'b00};
            SRL_CTRL1_OFS: st_d.prdata = {24'h000000, st_q.set_en, st_q.rst_en};
            SRL_CTRL2_OFS: st_d.prdata = {28'h0000000, st_q.ctrl2};
            SRL_STAT_OFS:  st_d.prdata = {28'h0000000, ext_latch_input,
                                          cmp_b_out_synced, cmp_a_out_synced,
                                          latch_q};
            default:       st_d.prdata = 32'h0000_0000;
         endcase
      end

      // strobes live one cycle; a new write re-arms them
      st_d.sw_set_strobe   = 1'b0; // R5
      st_d.sw_reset_strobe = 1'b0; // R5
      if (wr_ok) begin
         unique case (paddr)
            SRL_CTRL0_OFS: begin
               st_d.sw_set_strobe   = pwdata[SRL_SET_STB_BIT]; // R4
               st_d.sw_reset_strobe = pwdata[SRL_RST_STB_BIT]; // R4
               st_d.ctrl0.compl_out_en = pwdata[SRL_NQ_EN_BIT];
               st_d.ctrl0.true_out_en  = pwdata[SRL_Q_EN_BIT];
               st_d.ctrl0.periodic_clk_period_sel = pwdata[SRL_PSEL_LSB +: 3]; // R9
            end
            SRL_CTRL1_OFS: begin
               st_d.set_en = srl_src_s'(pwdata[SRL_SET_EN_LSB +: 4]); // R10
               st_d.rst_en = srl_src_s'(pwdata[SRL_RST_EN_LSB +: 4]); // R10
            end
            SRL_CTRL2_OFS: begin
               st_d.ctrl2.sync_a = pwdata[SRL_SYNC_A_BIT];
               st_d.ctrl2.sync_b = pwdata[SRL_SYNC_B_BIT];
               st_d.ctrl2.dir_q  = pwdata[SRL_DIR_Q_BIT];
               st_d.ctrl2.dir_nq = pwdata[SRL_DIR_NQ_BIT];
            end
            default: begin
            end
         endcase
      end

      // free-running divider for the periodic source
      st_d.per_cnt   = st_q.per_cnt + SRL_PER_CNT_W'(1);
      st_d.per_pulse = period_hit(st_q.per_cnt,
                                  st_q.ctrl0.periodic_clk_period_sel); // R9 R16

      // pin drivers; both may drive together
      st_d.q_pin   = latch_q;
      st_d.nq_pin  = ~latch_q;
      st_d.q_oe_n  = ~(st_q.ctrl0.true_out_en & ~st_q.ctrl2.dir_q);   // R11 R13 R12
      st_d.nq_oe_n = ~(st_q.ctrl0.compl_out_en & ~st_q.ctrl2.dir_nq); // R11 R13 R12
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata      = st_q.prdata;
   assign pready      = st_q.pready;
   assign pslverr     = st_q.pslverr;
   assign q_pin_out   = st_q.q_pin;
   assign q_pin_oe_n  = st_q.q_oe_n;
   assign nq_pin_out  = st_q.nq_pin;
   assign nq_pin_oe_n = st_q.nq_oe_n;
   assign latch_state = latch_q;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   reset_dominance_a: assert property (rst_eff |=> !latch_q) // R3
      else $error("latch not reset while reset source active");

   set_path_a: assert property (set_eff && !rst_eff |=> latch_q) // R15
      else $error("latch not set by an active set source");

   // latch has no reset: its level in the antecedent keeps these quiet until it is driven
   hold_state_a: assert property (!set_eff && !rst_eff && latch_q |=> latch_q) // R1
      else $error("latch dropped with no active source");

   hold_low_a: assert property (!set_eff && !rst_eff && !latch_q |=> !latch_q) // R1
      else $error("latch rose with no active source");

   sw_set_write_a: assert property (wr_ok && paddr == SRL_CTRL0_OFS &&
                                    pwdata[SRL_SET_STB_BIT] && !pwdata[SRL_RST_STB_BIT]
                                    && st_q.rst_en == 4'h0
                                    |=> st_q.sw_set_strobe ##1 latch_q) // R4
      else $error("software set write did not set latch");

   strobe_clear_a: assert property (st_q.sw_set_strobe || st_q.sw_reset_strobe
                                    |=> !(st_q.sw_set_strobe || st_q.sw_reset_strobe)
                                        || $past(wr_ok)) // R5
      else $error("strobe did not clear itself");

   ext_source_a: assert property (st_q.rst_en.ext && ext_latch_input |=> !latch_q) // R8
      else $error("external reset source ignored");

   cmp_bypass_a: assert property (!st_q.ctrl2.sync_a |-> cmp_a_out_synced == cmp_a_out) // R7
      else $error("comparator a bypass broken");

   period_pulse_a: assert property (st_q.per_pulse |=> !st_q.per_pulse [*3]) // R16
      else $error("periodic pulse longer than one cycle");

   period_set_a: assert property (st_q.per_pulse && st_q.set_en.per && !rst_eff
                                  |=> latch_q) // R10
      else $error("periodic clock did not set latch");

   pin_dir_a: assert property (st_q.ctrl2.dir_q |=> q_pin_oe_n) // R13
      else $error("true pin driven while direction is input");

   both_pins_a: assert property (st_q.ctrl0.true_out_en && st_q.ctrl0.compl_out_en &&
                                 !st_q.ctrl2.dir_q && !st_q.ctrl2.dir_nq
                                 |=> !q_pin_oe_n && !nq_pin_oe_n) // R12
      else $error("pins not driven together");

   compl_value_a: assert property (!nq_pin_oe_n |-> nq_pin_out == !q_pin_out) // R11
      else $error("complementary pin not inverse of true pin");

   apb_answer_a: assert property (setup |=> pready ##1 !pready)
      else $error("apb answer not one cycle after setup");

   cov_sw_set_c:   cover property (st_q.sw_set_strobe ##1 latch_q);
   cov_both_c:     cover property (set_eff && rst_eff);
   cov_periodic_c: cover property (st_q.per_pulse && st_q.rst_en.per);
   cov_pins_c:     cover property (!q_pin_oe_n && !nq_pin_oe_n);

endmodule

// ===== inc/srl_pkg.sv
// constants and carrier types of the set/reset latch block
// Function
// R1: latch state follows its set and reset inputs without a dedicated clock event
// R2: every set and reset input of the latch is active high
// R3: set and reset together drive the latch to, and hold it in, reset
// R4: one software bit sets the latch, another resets it
// R5: both software strobe bits clear themselves after one write
// R6: either comparator output may be chosen as set or reset source
// R7: comparator sources optionally pass a synchroniser clocked by the timer tick
// R8: the external input pin may be chosen as set or reset source
// R9: internal periodic clock with period chosen by a three-bit field
// R10: separate enables let the periodic clock set and/or reset the latch
// R11: separate enable bits gate true and complementary outputs to pins
// R12: true and complementary outputs may drive their pins simultaneously
// R13: a latch output reaches its pin only while its direction bit is cleared
// R14: device reset leaves latch state undefined; software initialises it first
// R15: effective set/reset is the OR of all enabled set/reset sources
// R16: periodic clock gives a one-cycle pulse once per selected period
package srl_pkg;

   // register byte offsets
   localparam logic [7:0] SRL_CTRL0_OFS = 8'h00;
   localparam logic [7:0] SRL_CTRL1_OFS = 8'h04;
   localparam logic [7:0] SRL_CTRL2_OFS = 8'h08;
   localparam logic [7:0] SRL_STAT_OFS  = 8'h0c;

   // latch_control_reg0 fields
   localparam int SRL_RST_STB_BIT = 0;
   localparam int SRL_SET_STB_BIT = 1;
   localparam int SRL_NQ_EN_BIT   = 2;
   localparam int SRL_Q_EN_BIT    = 3;
   localparam int SRL_PSEL_LSB    = 4;

   // latch_control_reg1: reset enables in [3:0], set enables in [7:4]
   localparam int SRL_RST_EN_LSB = 0;
   localparam int SRL_SET_EN_LSB = 4;

   // control 2 fields
   localparam int SRL_SYNC_A_BIT = 0;
   localparam int SRL_SYNC_B_BIT = 1;
   localparam int SRL_DIR_Q_BIT  = 2;
   localparam int SRL_DIR_NQ_BIT = 3;

   // reset values; direction bits come up as input
   localparam logic [4:0] SRL_CTRL0_RST = 5'h00;
   localparam logic [7:0] SRL_CTRL1_RST = 8'h00;
   localparam logic [3:0] SRL_CTRL2_RST = 4'hc;

   // periodic clock: period is 2**(sel + base) core cycles
   localparam int SRL_PER_BASE  = 2;
   localparam int SRL_PER_CNT_W = 10;

   typedef struct packed {
      logic [2:0] periodic_clk_period_sel;
      logic       true_out_en;
      logic       compl_out_en;
   } srl_ctrl0_s;

   // one enable per latch source, bit 0 is comparator b
   typedef struct packed {
      logic per;
      logic ext;
      logic cmp_a;
      logic cmp_b;
   } srl_src_s;

   typedef struct packed {
      logic dir_nq;
      logic dir_q;
      logic sync_b;
      logic sync_a;
   } srl_ctrl2_s;

   typedef struct packed {
      srl_ctrl0_s               ctrl0;
      srl_src_s                 set_en;
      srl_src_s                 rst_en;
      srl_ctrl2_s               ctrl2;
      logic                     sw_set_strobe;
      logic                     sw_reset_strobe;
      logic [SRL_PER_CNT_W-1:0] per_cnt;
      logic                     per_pulse;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic                     q_pin;
      logic                     q_oe_n;
      logic                     nq_pin;
      logic                     nq_oe_n;
   } srl_state_s;

endpackage

// ===== design/srl_cmp_sync.sv
// comparator synchroniser stepped by the timer clock tick
`timescale 1ns/10ps
module srl_cmp_sync
   import srl_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // control
   input  wire logic tick,
   input  wire logic sync_en,
   // data
   input  wire logic raw,
   output logic      out
);

   logic meta_q;
   logic stage_q;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q  <= 1'b0;
         stage_q <= 1'b0;
      end else if (tick) begin
         meta_q  <= raw;
         stage_q <= meta_q;
      end
   end

   // bypass gives the fastest response when sync is off
   assign out = sync_en ? stage_q : raw; // R7

endmodule

// ===== tb/srl_far_side.sv
// far-side model: comparators, external source pin, timer tick and pin wires
`timescale 1ns/10ps
module srl_far_side
(
   // clock
   input  wire logic ref_clk,
   // levels asked for by the bench
   input  wire logic a_req,
   input  wire logic b_req,
   input  wire logic e_req,
   // toward the block
   output logic      cmp_a_out,
   output logic      cmp_b_out,
   output logic      ext_latch_input,
   output logic      t1_clk_en,
   // pin drivers of the block
   input  wire logic q_pin_out,
   input  wire logic q_pin_oe_n,
   input  wire logic nq_pin_out,
   input  wire logic nq_pin_oe_n,
   output logic      q_wire,
   output logic      nq_wire
);
   logic [2:0] tick_q;
   initial begin
      tick_q = 3'h0;
      t1_clk_en = 1'b0;
      cmp_a_out = 1'b0;
      cmp_b_out = 1'b0;
      ext_latch_input = 1'b0;
   end
   // comparators are synchronous to the core clock; the tick is slow on purpose
   always @(posedge ref_clk) begin
      tick_q <= tick_q + 3'h1;
      t1_clk_en <= (tick_q == 3'h7);
      cmp_a_out <= a_req;
      cmp_b_out <= b_req;
      ext_latch_input <= e_req;
   end
   // released pins sit on a weak pull-down
   assign q_wire  = q_pin_oe_n ? 1'b0 : q_pin_out;
   assign nq_wire = nq_pin_oe_n ? 1'b0 : nq_pin_out;
endmodule

// ===== tb/srl_latch_tb.sv
// self-checking bench of the set/reset latch over apb
`timescale 1ns/10ps
module srl_latch_tb
   import srl_pkg::*;
;
   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cmp_a_out;
   logic        cmp_b_out;
   logic        t1_clk_en;
   logic        ext_latch_input;
   logic        q_pin_out;
   logic        q_pin_oe_n;
   logic        nq_pin_out;
   logic        nq_pin_oe_n;
   logic        latch_state;
   logic        a_req;
   logic        b_req;
   logic        e_req;
   logic        q_wire;
   logic        nq_wire;
   logic [31:0] rd;
   logic        er;
   int          checks;
   int          n_errors;
   int          n;

   srl_latch i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_a_out(cmp_a_out), .cmp_b_out(cmp_b_out),
      .t1_clk_en(t1_clk_en), .ext_latch_input(ext_latch_input), .q_pin_out(q_pin_out),
      .q_pin_oe_n(q_pin_oe_n), .nq_pin_out(nq_pin_out), .nq_pin_oe_n(nq_pin_oe_n),
      .latch_state(latch_state));
   srl_far_side i_far (.ref_clk(ref_clk), .a_req(a_req), .b_req(b_req), .e_req(e_req),
      .cmp_a_out(cmp_a_out), .cmp_b_out(cmp_b_out), .ext_latch_input(ext_latch_input),
      .t1_clk_en(t1_clk_en), .q_pin_out(q_pin_out), .q_pin_oe_n(q_pin_oe_n),
      .nq_pin_out(nq_pin_out), .nq_pin_oe_n(nq_pin_oe_n), .q_wire(q_wire),
      .nq_wire(nq_wire));

   always #4 ref_clk = ~ref_clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic fail_stop(input string m);
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
      report_and_stop();
   endtask

   task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e, input string m);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %s got %b want %b", $time, m, g, e);
      end
   endtask

   // holds the request until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 50)
         fail_stop("no pready");
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      xfer(1'b0, a, 32'h0);
      chk32(rd, e, "read data");
      chk1(er, ee, "read error");
   endtask

   task automatic wait_lat(input logic e, input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         @(posedge ref_clk);
         if (latch_state === e)
            break;
      end
      checks++;
      if (i == bound)
         fail_stop("latch never changed");
   endtask

   task automatic stay(input logic e);
      repeat (4) @(posedge ref_clk);
      chk1(latch_state, e, "latch held");
   endtask

   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      a_req = 1'b0;
      b_req = 1'b0;
      e_req = 1'b0;
      checks = 0;
      n_errors = 0;
      repeat (5) @(posedge ref_clk);
      chk1(q_pin_oe_n, 1'b1, "pin driven in reset");
      rst_n <= 1'b1;
      rd_chk(SRL_CTRL0_OFS, 32'h0, 1'b0);
      rd_chk(SRL_CTRL1_OFS, 32'h0, 1'b0);
      rd_chk(SRL_CTRL2_OFS, 32'hc, 1'b0);
      rd_chk(8'h10, 32'h0, 1'b1);
      xfer(1'b1, 8'h10, 32'hff);
      chk1(er, 1'b1, "unmapped write");
      $display("test registers done");
      // latch is unknown after reset, so strobe before any pin is enabled
      xfer(1'b1, SRL_CTRL0_OFS, 32'h2);
      wait_lat(1'b1, 4);
      rd_chk(SRL_CTRL0_OFS, 32'h0, 1'b0);
      xfer(1'b1, SRL_CTRL0_OFS, 32'h3);
      stay(1'b0);
      xfer(1'b1, SRL_CTRL0_OFS, 32'h2);
      wait_lat(1'b1, 4);
      xfer(1'b1, SRL_CTRL1_OFS, 32'h04);
      e_req <= 1'b1;
      wait_lat(1'b0, 4);
      e_req <= 1'b0;
      stay(1'b0);
      xfer(1'b1, SRL_CTRL1_OFS, 32'h40);
      e_req <= 1'b1;
      wait_lat(1'b1, 4);
      xfer(1'b1, SRL_CTRL0_OFS, 32'h1);
      wait_lat(1'b0, 4);
      wait_lat(1'b1, 4);
      xfer(1'b1, SRL_CTRL1_OFS, 32'h44);
      stay(1'b0);
      e_req <= 1'b0;
      $display("test strobes and pin source done");
      xfer(1'b1, SRL_CTRL1_OFS, 32'h20);
      a_req <= 1'b1;
      b_req <= 1'b1;
      wait_lat(1'b1, 4);
      stay(1'b1);
      xfer(1'b1, SRL_CTRL1_OFS, 32'h21);
      wait_lat(1'b0, 4);
      a_req <= 1'b0;
      b_req <= 1'b0;
      // stale level in the stages would set the latch early once sync is on
      repeat (20) @(posedge ref_clk);
      // synchronised path waits two timer ticks, so it must lag the direct one
      xfer(1'b1, SRL_CTRL2_OFS, 32'hd);
      xfer(1'b1, SRL_CTRL1_OFS, 32'h20);
      a_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk1(latch_state, 1'b0, "sync bypassed");
      wait_lat(1'b1, 40);
      a_req <= 1'b0;
      $display("test comparators done");
      // pin source holds set, periodic reset dips the latch for one cycle
      xfer(1'b1, SRL_CTRL2_OFS, 32'hc);
      xfer(1'b1, SRL_CTRL1_OFS, 32'h48);
      e_req <= 1'b1;
      for (int s = 0; s < 8; s++) begin
         xfer(1'b1, SRL_CTRL0_OFS, 32'(s) << SRL_PSEL_LSB);
         repeat (2) wait_lat(1'b0, 1100);
         wait_lat(1'b1, 2);
         n = 1;
         wait_lat(1'b0, 1100);
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (latch_state !== 1'b0 && n < 1100);
         chk32(32'(n), 32'h1 << (s + SRL_PER_BASE), "period");
      end
      e_req <= 1'b0;
      xfer(1'b1, SRL_CTRL1_OFS, 32'h80);
      xfer(1'b1, SRL_CTRL0_OFS, 32'h1);
      wait_lat(1'b0, 4);
      wait_lat(1'b1, 8);
      $display("test periodic done");
      xfer(1'b1, SRL_CTRL1_OFS, 32'h0);
      xfer(1'b1, SRL_CTRL0_OFS, 32'he);
      stay(1'b1);
      chk1(q_pin_oe_n, 1'b1, "pin dir input");
      xfer(1'b1, SRL_CTRL2_OFS, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk1(q_pin_oe_n, 1'b0, "q oe");
      chk1(nq_pin_oe_n, 1'b0, "nq oe");
      chk1(q_wire, 1'b1, "q pin");
      chk1(nq_wire, 1'b0, "nq pin");
      xfer(1'b1, SRL_CTRL0_OFS, 32'h4);
      repeat (3) @(posedge ref_clk);
      chk1(q_pin_oe_n, 1'b1, "q off");
      chk1(nq_pin_oe_n, 1'b0, "nq on");
      xfer(1'b0, SRL_STAT_OFS, 32'h0);
      chk1(rd[0], 1'b1, "status latch");
      $display("test outputs done");
      report_and_stop();
   end
endmodule
